/* File: rtl/node_status_pkg.sv */
/*
 Constants for the node status flag register block: register offsets, bit positions,
 reset values and timing. Assumes a plain synchronous register port on clk_sys.
*/
`default_nettype none
package node_status_pkg;
   localparam logic [2:0] ADDR_STATUS   = 3'h0;
   localparam logic [2:0] ADDR_COMMAND  = 3'h1;
   localparam logic [2:0] ADDR_NODE_ID  = 3'h2;
   localparam logic [2:0] ADDR_INT_MASK = 3'h3;
   localparam logic [2:0] ADDR_EVENTS   = 3'h4;
   localparam logic [2:0] ADDR_EV_MASK  = 3'h5;

   localparam int BIT_RX_INHIBITED = 7;
   localparam int BIT_RESET_SEEN   = 4;
   localparam int BIT_TEST         = 3;
   localparam int BIT_RECONFIG     = 2;
   localparam int BIT_TX_ACKED     = 1;
   localparam int BIT_TX_AVAILABLE = 0;

   localparam logic [7:0] STATUS_RESET   = 8'h91;
   localparam logic [7:0] INT_MASK_RESET = 8'h00;
   localparam logic [7:0] NODE_ID_CLEAR  = 8'h00;

   localparam logic [3:0] CMD_DISABLE_TX  = 4'h1;
   localparam logic [3:0] CMD_ENABLE_TX   = 4'h3;
   localparam logic [3:0] CMD_ENABLE_RX   = 4'h4;
   localparam logic [3:0] CMD_CLEAR_FLAGS = 4'h6;
   localparam logic [3:0] CMD_SOFT_RESET  = 4'h8;

   localparam int EV_RX_STORED = 0;
   localparam int EV_NAK_SENT  = 1;
   localparam int EV_RECON     = 2;
   localparam int EV_TX_DONE   = 3;

   localparam real CLK_MHZ       = 10.0;
   localparam real IDLE_LIMIT_US = 20.5;
   // The idle limit is a whole number of cycles at 10 MHz, so no rounding up is wanted
   localparam int  IDLE_CYCLES   = int'(IDLE_LIMIT_US * CLK_MHZ);
endpackage : node_status_pkg
`default_nettype wire

/* File: rtl/node_status_flags.sv */
/*
 Status flag register of a token-passing network node with its command decode, line
 idle timer and event interrupt. Assumes protocol logic on clk_sys supplying one-cycle
 event pulses, and an asynchronous receive line input synchronised here.
*/
// The register offsets and the plain strobed port were decided locally.
`default_nettype none
// Notes on behaviour
// - Receiver-inhibited bit 7 sets once a packet is stored in the enabled page.
// - Enable-receive clears receiver-inhibited; no messages accepted while it is set.
// - While receiver-inhibited, answer incoming packets for this node with a NAK.
// - Interrupt when inhibited, reconfig or tx-available flag is set and mask bit set.
// - Bits 6 and 5 are undefined; host ignores them.
// - Reset-seen bit 4 sets on software or hardware reset or node id write of 00H.
// - Reset-seen clears only on the clear-flags command.
// - Bit 3 is a test bit and reads zero in normal operation.
// - Reconfig bit 2 sets when the receive line idles for 20.5 us.
// - Clear-flags command clears the reconfig flag.
// - Tx-acked bit 1 sets when the enabled transmit packet is acknowledged.
// - Tx-acked never sets for a broadcast packet.
// - Enable-transmit clears tx-acked.
// - Tx-available sets when the last byte leaves or on disable-transmitter.
// - After enable-transmit, tx-available clears only when the token next arrives.
// - Reset loads status with 1XX1 0001.
module node_status_flags #(
   parameter int IDLE_COUNT = node_status_pkg::IDLE_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // Receiver side
   input  wire logic       rx_line_input,
   input  wire logic       rx_packet_stored,
   input  wire logic       rx_packet_offered,
   output logic            rx_enabled,
   output logic            rx_nak_send,
   // Transmitter side
   input  wire logic       token_received,
   input  wire logic       tx_last_byte_sent,
   input  wire logic       tx_acked,
   input  wire logic       tx_was_broadcast,
   output logic            tx_start,
   // Reset and interrupt
   output logic            soft_reset_pulse,
   output logic            irq
);
   logic [7:0] interrupt_mask;
   logic [7:0] node_id;
   logic [3:0] event_status;
   logic [3:0] event_mask;
   logic       rx_inhibited_flag;
   logic       reset_seen_flag;
   logic       reconfig_flag;
   logic       tx_acked_flag;
   logic       tx_available_flag;
   logic       tx_pending;
   logic       line_meta;
   logic       line_sync;
   logic       line_prev;
   logic [$clog2(IDLE_COUNT+1)-1:0] idle_count;
   logic       idle_expired;
   logic [7:0] status_value;
   logic [3:0] cmd_code;
   logic       cmd_write;
   logic       cmd_enable_rx;
   logic       cmd_enable_tx;
   logic       cmd_disable_tx;
   logic       cmd_clear_flags;
   logic       cmd_soft_reset;
   logic       node_id_zero_write;
   logic [3:0] event_pulses;

   initial begin
      if (IDLE_COUNT < 2) $error("IDLE_COUNT must be at least 2");
   end

   assign cmd_code        = reg_wdata[3:0];
   assign cmd_write       = reg_write && (reg_addr == node_status_pkg::ADDR_COMMAND);
   assign cmd_enable_rx   = cmd_write && (cmd_code == node_status_pkg::CMD_ENABLE_RX);
   assign cmd_enable_tx   = cmd_write && (cmd_code == node_status_pkg::CMD_ENABLE_TX);
   assign cmd_disable_tx  = cmd_write && (cmd_code == node_status_pkg::CMD_DISABLE_TX);
   assign cmd_clear_flags = cmd_write && (cmd_code == node_status_pkg::CMD_CLEAR_FLAGS);
   assign cmd_soft_reset  = cmd_write && (cmd_code == node_status_pkg::CMD_SOFT_RESET);
   assign node_id_zero_write = reg_write && (reg_addr == node_status_pkg::ADDR_NODE_ID)
                               && (reg_wdata == node_status_pkg::NODE_ID_CLEAR);

   // Synchroniser; only line_sync and line_prev are looked at
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         line_meta <= 1'b0;
         line_sync <= 1'b0;
         line_prev <= 1'b0;
      end else begin
         line_meta <= rx_line_input;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end

   // Idle timer restarts on any line edge, fires once per idle stretch
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         idle_count   <= '0;
         idle_expired <= 1'b0;
      end else if (line_sync != line_prev) begin
         idle_count   <= '0;
         idle_expired <= 1'b0;
      end else if (idle_count == ($bits(idle_count))'(IDLE_COUNT - 1)) begin
         idle_count   <= idle_count + 1'b1;
         idle_expired <= 1'b1;
      end else begin
         if (idle_count < ($bits(idle_count))'(IDLE_COUNT)) begin
            idle_count <= idle_count + 1'b1;
         end
         idle_expired <= 1'b0;
      end
   end

   // Receiver inhibit; a store in the same cycle as enable wins
   always_ff @(posedge clk_sys) begin
      if (!rst_b || cmd_soft_reset) begin
         rx_inhibited_flag <= node_status_pkg::STATUS_RESET[node_status_pkg::BIT_RX_INHIBITED];
      end else if (rx_packet_stored && !rx_inhibited_flag) begin
         rx_inhibited_flag <= 1'b1;
      end else if (cmd_enable_rx) begin
         rx_inhibited_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_enabled  <= 1'b0;
         rx_nak_send <= 1'b0;
      end else begin
         rx_enabled  <= !rx_inhibited_flag;
         rx_nak_send <= rx_packet_offered && rx_inhibited_flag;
      end
   end

   // Reset seen: set wins over clear-flags
   always_ff @(posedge clk_sys) begin
      if (!rst_b || cmd_soft_reset || node_id_zero_write) begin
         reset_seen_flag <= 1'b1;
      end else if (cmd_clear_flags) begin
         reset_seen_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b || cmd_soft_reset) begin
         reconfig_flag <= node_status_pkg::STATUS_RESET[node_status_pkg::BIT_RECONFIG];
      end else if (idle_expired) begin
         reconfig_flag <= 1'b1;
      end else if (cmd_clear_flags) begin
         reconfig_flag <= 1'b0;
      end
   end

   // Transmit handshake; clearing waits for the token so the flag tracks the real transmitter
   always_ff @(posedge clk_sys) begin
      if (!rst_b || cmd_soft_reset) begin
         tx_pending        <= 1'b0;
         tx_available_flag <= node_status_pkg::STATUS_RESET[node_status_pkg::BIT_TX_AVAILABLE];
         tx_start          <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         if (cmd_disable_tx) begin
            tx_pending        <= 1'b0;
            tx_available_flag <= 1'b1;
         end else begin
            // An enable arriving with the last byte must not be lost
            if (tx_last_byte_sent && !tx_available_flag) begin
               tx_available_flag <= 1'b1;
            end
            if (cmd_enable_tx) begin
               tx_pending <= 1'b1;
            end else if (tx_pending && token_received) begin
               tx_pending        <= 1'b0;
               tx_available_flag <= 1'b0;
               tx_start          <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b || cmd_soft_reset) begin
         tx_acked_flag <= node_status_pkg::STATUS_RESET[node_status_pkg::BIT_TX_ACKED];
      end else if (tx_acked && !tx_was_broadcast && !tx_available_flag) begin
         tx_acked_flag <= 1'b1;
      end else if (cmd_enable_tx) begin
         tx_acked_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         soft_reset_pulse <= 1'b0;
         node_id          <= node_status_pkg::NODE_ID_CLEAR;
         interrupt_mask   <= node_status_pkg::INT_MASK_RESET;
         event_mask       <= 4'h0;
      end else begin
         soft_reset_pulse <= cmd_soft_reset;
         if (reg_write && reg_addr == node_status_pkg::ADDR_NODE_ID) begin
            node_id <= reg_wdata;
         end
         if (reg_write && reg_addr == node_status_pkg::ADDR_INT_MASK) begin
            interrupt_mask <= reg_wdata;
         end
         if (reg_write && reg_addr == node_status_pkg::ADDR_EV_MASK) begin
            event_mask <= reg_wdata[3:0];
         end
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   assign event_pulses[node_status_pkg::EV_RX_STORED] = rx_packet_stored;
   assign event_pulses[node_status_pkg::EV_NAK_SENT]  = rx_packet_offered && rx_inhibited_flag;
   assign event_pulses[node_status_pkg::EV_RECON]     = idle_expired;
   assign event_pulses[node_status_pkg::EV_TX_DONE]   = tx_last_byte_sent;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         event_status <= 4'h0;
      end else if (reg_write && reg_addr == node_status_pkg::ADDR_EVENTS) begin
         event_status <= (event_status & ~reg_wdata[3:0]) | event_pulses;
      end else begin
         event_status <= event_status | event_pulses;
      end
   end

   // Bits 6:5 read zero; bit 3 is the test bit, zero in normal operation
   assign status_value = {rx_inhibited_flag, 2'b00, reset_seen_flag, 1'b0,
                          reconfig_flag, tx_acked_flag, tx_available_flag};

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= (rx_inhibited_flag && interrupt_mask[node_status_pkg::BIT_RX_INHIBITED])
             || (reconfig_flag && interrupt_mask[node_status_pkg::BIT_RECONFIG])
             || (tx_available_flag && interrupt_mask[node_status_pkg::BIT_TX_AVAILABLE])
             || ((event_status & event_mask) != 4'h0);
      end
   end

   // Reads have no side effects
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            node_status_pkg::ADDR_STATUS:   reg_rdata <= status_value;
            node_status_pkg::ADDR_NODE_ID:  reg_rdata <= node_id;
            node_status_pkg::ADDR_INT_MASK: reg_rdata <= interrupt_mask;
            node_status_pkg::ADDR_EVENTS:   reg_rdata <= {4'h0, event_status};
            node_status_pkg::ADDR_EV_MASK:  reg_rdata <= {4'h0, event_mask};
            default:                        reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : node_status_flags
`default_nettype wire

/* File: bench/node_status_assertions.sv */
/* Port checker for node_status_flags, bound below.
   Assumes the package is compiled first. */
`default_nettype none
module node_status_assertions #(parameter int IDLE_COUNT = 8) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   // Protocol side and interrupt
   input wire logic       rx_packet_offered,
   input wire logic       rx_enabled,
   input wire logic       rx_nak_send,
   input wire logic       token_received,
   input wire logic       tx_start,
   input wire logic       soft_reset_pulse,
   input wire logic       irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic cmd_wr, en_rx, soft_cmd, mask_seen;
   assign cmd_wr = reg_write && reg_addr == node_status_pkg::ADDR_COMMAND;
   assign en_rx = cmd_wr && reg_wdata[3:0] == node_status_pkg::CMD_ENABLE_RX;
   assign soft_cmd = cmd_wr && reg_wdata[3:0] == node_status_pkg::CMD_SOFT_RESET;
   // Masks reset to zero; odd offsets other than the command cover both masks
   always_ff @(posedge clk_sys) begin
      if (!rst_b) mask_seen <= 1'b0;
      else if (reg_write && reg_addr[0] && !cmd_wr) mask_seen <= 1'b1;
   end
   a_rdata_quiet: assert property (
      !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
   a_test_bit_low: assert property (
      $past(reg_read) && $past(reg_addr) == node_status_pkg::ADDR_STATUS |-> !reg_rdata[3])
      else $error("test bit set");
   a_nak_inhibit: assert property (
      rx_packet_offered && !rx_enabled && !$past(reg_write) |=> rx_nak_send) else $error("no nak");
   a_nak_cause: assert property (
      rx_nak_send |-> $past(rx_packet_offered)) else $error("nak without offer");
   a_rx_enable: assert property (
      $rose(rx_enabled) |-> $past(en_rx, 2)) else $error("receiver enabled without command");
   a_start_token: assert property (
      tx_start |-> $past(token_received)) else $error("transmit start without token");
   a_soft_pulse: assert property (
      soft_reset_pulse == $past(soft_cmd)) else $error("soft reset pulse mismatch");
   a_irq_masked: assert property (
      !mask_seen |-> !irq) else $error("interrupt with masks clear");
   c_nak: cover property (rx_nak_send);
   c_start: cover property (tx_start);
   c_irq: cover property (irq);
endmodule : node_status_assertions
bind node_status_flags node_status_assertions #(.IDLE_COUNT(IDLE_COUNT)) u_checker (.clk_sys, .rst_b, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_packet_offered, .rx_enabled, .rx_nak_send,
   .token_received, .tx_start, .soft_reset_pulse, .irq);
`default_nettype wire

/* File: bench/line_model.sv */
/* Far-side receive line: toggles while busy, holds its level when idle.
   Assumes clk_sys from the bench. */
`default_nettype none
module line_model (
   // Clock and control
   input wire logic clk_sys,
   input wire logic busy,
   // Line towards the node
   output var logic rx_line_input
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rx_line_input = 1'b0;
   // Only activity defers the idle timer, so a held level is a true idle
   always @(posedge clk_sys) if (busy) rx_line_input <= ~rx_line_input;
endmodule : line_model
`default_nettype wire

/* File: bench/testbench.sv */
/* Bench for node_status_flags: register tasks, event pulses, random masks.
   Assumes package, checker and line model compile first. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0, busy = 1'b1, bcast = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [4:0] evp = 5'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, m;
   logic       rx_line_input, irq;
   int         n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 32'h2553C84C;
   node_status_flags #(.IDLE_COUNT(8)) i_node_status_flags (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .rx_line_input, .rx_packet_stored(evp[0]), .rx_packet_offered(evp[1]),
      .rx_enabled(), .rx_nak_send(), .token_received(evp[2]), .tx_last_byte_sent(evp[4]), .tx_acked(evp[3]),
      .tx_was_broadcast(bcast), .tx_start(), .soft_reset_pulse(), .irq);
   line_model i_line_model (.clk_sys, .busy, .rx_line_input);
   always #50 clk_sys = ~clk_sys;
   // The run needs well under a thousand cycles; this only cuts a hang
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end
   function automatic logic [7:0] stat(input logic ri, po, rc, tm, ta);
      return {ri, 2'b00, po, 1'b0, rc, tm, ta};
   endfunction : stat
   task automatic chk(input string what, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic cmd(input logic [3:0] c);
      wr(node_status_pkg::ADDR_COMMAND, {4'h0, c});
   endtask : cmd
   task automatic rd(input logic [2:0] a, input logic [7:0] msk, exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk($sformatf("reg %0d", a), reg_rdata & msk, exp);
      @(posedge clk_sys);
   endtask : rd
   // Bits 6 and 5 carry nothing, so they are masked off
   task automatic st(input logic [7:0] e);
      rd(node_status_pkg::ADDR_STATUS, 8'h9F, e);
   endtask : st
   task automatic ev(input int k);
      evp[k] <= 1'b1;
      @(posedge clk_sys);
      evp <= 5'h00;
      @(posedge clk_sys);
   endtask : ev
   task automatic ck_irq(input logic e);
      @(posedge clk_sys);
      #1 chk("irq", {7'h00, irq}, {7'h00, e});
      @(posedge clk_sys);
   endtask : ck_irq
   task automatic conclude();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      st(stat(1, 1, 0, 0, 1));
      st(stat(1, 1, 0, 0, 1));
      rd(3'h7, 8'hFF, 8'h00);
      wr(node_status_pkg::ADDR_STATUS, 8'($random(seed)));
      cmd(node_status_pkg::CMD_CLEAR_FLAGS);
      st(stat(1, 0, 0, 0, 1));
      wr(node_status_pkg::ADDR_NODE_ID, 8'($random(seed)) | 8'h01);
      st(stat(1, 0, 0, 0, 1));
      wr(node_status_pkg::ADDR_NODE_ID, 8'h00);
      st(stat(1, 1, 0, 0, 1));
      ev(1);
      cmd(node_status_pkg::CMD_ENABLE_RX);
      st(stat(0, 1, 0, 0, 1));
      ev(1);
      ev(0);
      st(stat(1, 1, 0, 0, 1));
      // Second pass is broadcast and must stay unacknowledged
      for (int b = 0; b < 2; b++) begin
         bcast <= b[0];
         cmd(node_status_pkg::CMD_ENABLE_TX);
         st(stat(1, 1, 0, 0, 1));
         ev(2);
         st(stat(1, 1, 0, 0, 0));
         ev(3);
         ev(4);
         st(stat(1, 1, 0, !b[0], 1));
      end
      cmd(node_status_pkg::CMD_ENABLE_TX);
      ev(2);
      cmd(node_status_pkg::CMD_DISABLE_TX);
      st(stat(1, 1, 0, 0, 1));
      busy <= 1'b0;
      repeat (20) @(posedge clk_sys);
      busy <= 1'b1;
      st(stat(1, 1, 1, 0, 1));
      repeat (6) begin
         m = 8'($random(seed));
         wr(node_status_pkg::ADDR_INT_MASK, m);
         ck_irq(|(m & 8'h85));
      end
      cmd(node_status_pkg::CMD_CLEAR_FLAGS);
      wr(node_status_pkg::ADDR_INT_MASK, 8'h04);
      ck_irq(1'b0);
      st(stat(1, 0, 0, 0, 1));
      rd(node_status_pkg::ADDR_EVENTS, 8'hFF, 8'h0F);
      wr(node_status_pkg::ADDR_EV_MASK, 8'h01);
      ck_irq(1'b1);
      wr(node_status_pkg::ADDR_EVENTS, 8'h01);
      ck_irq(1'b0);
      cmd(node_status_pkg::CMD_ENABLE_RX);
      cmd(node_status_pkg::CMD_SOFT_RESET);
      st(stat(1, 1, 0, 0, 1));
      conclude();
   end
endmodule : testbench
`default_nettype wire
